// ==== verilog/adc_i2c_slave.sv ====
// Purpose: two-wire serial slave front end of a 12-bit SAR converter
// Assumes: SCL and SDA are sampled by CLK_SYS through synchronisers
// Notes: the converter core itself sits outside, behind CONV_* ports
// Function
// - device is slave only; master makes clock, START and STOP up to 3.4MHz
// - data falling while clock high is a START, beginning a transfer
// - data rising while clock high is a STOP, ending a transfer
// - data stays stable during clock high; changes there are conditions
// - bytes move one bit per clock, receiver acknowledges in a ninth bit
// - acknowledger holds data low across the whole acknowledge high phase
// - master withholds last acknowledge; slave releases data for STOP
// - repeated START ends a transfer and restarts address reception
// - first byte is the address; five top bits match the fixed prefix
// - next two bits match the strap pins sampled at startup
// - last address bit: 1 reads from device, 0 writes to it
// - acknowledge only on a full address match, otherwise stay silent
// - in writes acknowledge the address and every received byte
// - in reads shift bytes out on master clock, sample master acknowledge
// - input-mode bit selects differential at 0, single-ended at 1
// - command holds three channel bits, two power bits, unused ignored
// - power bits pick between-conversion, ref off, conv off, both on
// - core clock is off when idle and not addressed; core power too, unless conv_power_sel is set
// - results are straight 12-bit codes, step equals reference over 4096
// - channel routing: single-ended against common, differential pairs
// - result returned upper byte first, four zeros then bits 11 to 8
// - reference power change takes effect at next STOP or repeated START
// - after a write address, conversion begins once the command arrives
`timescale 1ns/10ps
module adc_i2c_slave
  import adc_cmd_pkg::*;
(
  input wire logic CLK_SYS, // system clock, 100 MHz
  input wire logic RST_N, // async reset, active low
  input wire logic SCL_IN, // serial clock pin level
  input wire logic SDA_IN, // serial data pin level
  output logic SDA_OUT, // serial data drive value, always low
  output logic SDA_OE, // high while pulling serial data low
  input wire logic ADDR_STRAP_HI, // address select pin, high bit
  input wire logic ADDR_STRAP_LO, // address select pin, low bit
  output logic CONV_START, // one-cycle pulse, start a conversion
  input wire logic CONV_DONE, // one-cycle pulse from the core
  input wire logic [RESULT_W-1:0] CONV_RESULT, // straight binary code
  output adc_cmd_pkg::route_s MUX_ROUTE, // analog input routing
  output logic INPUT_MODE_SEL, // 1 single-ended, 0 differential
  output logic REF_ON, // internal reference powered
  output logic CONV_POWER_ON, // converter core powered
  output logic CORE_CLK_EN, // internal core clock running
  output logic ADDRESSED // device selected by the master
);
  import adc_cmd_pkg::*;

  logic scl_s;
  logic sda_s;
  logic [1:0] strap_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  state_e st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic sda_oe_q;
  logic rw_q;
  logic nack_q;
  logic byte_hi_q;
  logic [1:0] strap_q;
  logic [1:0] strap_cnt_q;
  logic addr_match;
  cmd_s cmd_q;
  logic ref_pend_q;
  logic ref_on_q;
  logic conv_pend_q;
  logic conv_busy_q;
  logic conv_start_q;
  logic conv_pwr_q;
  logic clk_en_q;
  logic addressed_q;
  route_s route_q;
  logic mode_q;
  logic [RESULT_W-1:0] word_q;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [RESULT_W-1:0] fifo_rd_data;
  logic load_hi;
  logic load_lo;
  logic rx_done;
  logic tx_next;

  sync2 #(.W(2), .INIT(2'h3)) u_sync_bus (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d({SCL_IN, SDA_IN}),
    .q({scl_s, sda_s})
  );

  sync2 #(.W(2), .INIT(2'h0)) u_sync_strap (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d({ADDR_STRAP_HI, ADDR_STRAP_LO}),
    .q(strap_s)
  );

  // results wait here; a full buffer holds off the next conversion
  result_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .wr_valid(CONV_DONE),
    .wr_ready(fifo_wr_ready),
    .wr_data(CONV_RESULT),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data)
  );

  // straps caught once the synchroniser has settled after reset
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      strap_cnt_q <= STRAP_CNT_RESET;
      strap_q <= 2'h0;
    end else if (strap_cnt_q != STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      strap_q <= strap_s;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  // data moving while the clock stays high is a condition, not a bit
  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

  assign addr_match = (rx_sh_q[7:3] == DEV_PREFIX) &&
                      (rx_sh_q[2:1] == strap_q);
  assign rx_done = (st_q == ST_RX) && scl_fall && (bit_cnt_q == BYTE_BITS);
  assign tx_next = (st_q == ST_ADDR_ACK && rw_q == RW_READ) ||
                   (st_q == ST_TX_ACK && !nack_q);
  assign load_hi = scl_fall && tx_next && !byte_hi_q;
  assign load_lo = scl_fall && tx_next && byte_hi_q;
  assign fifo_rd_ready = load_hi;

  // bus state machine; the master owns clock and conditions
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      bit_cnt_q <= CNT_RESET;
      sda_oe_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (start_det) begin
      st_q <= ST_ADDR;
      bit_cnt_q <= CNT_RESET;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      st_q <= ST_IDLE;
      bit_cnt_q <= CNT_RESET;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == ST_ADDR || st_q == ST_RX || st_q == ST_TX) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end else if (scl_fall) begin
      case (st_q)
        ST_ADDR: begin
          if (bit_cnt_q == BYTE_BITS) begin
            bit_cnt_q <= CNT_RESET;
            rw_q <= rx_sh_q[0];
            if (addr_match) begin
              st_q <= ST_ADDR_ACK;
              sda_oe_q <= 1'b1;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (rw_q == RW_READ) begin
            st_q <= ST_TX;
            sda_oe_q <= (HI_BYTE_PAD[3] == 1'b0);
          end else begin
            st_q <= ST_RX;
            sda_oe_q <= 1'b0;
          end
        end
        ST_RX: begin
          if (bit_cnt_q == BYTE_BITS) begin
            st_q <= ST_RX_ACK;
            bit_cnt_q <= CNT_RESET;
            sda_oe_q <= 1'b1;
          end
        end
        ST_RX_ACK: begin
          st_q <= ST_RX;
          sda_oe_q <= 1'b0;
        end
        ST_TX: begin
          if (bit_cnt_q == BYTE_BITS) begin
            st_q <= ST_TX_ACK;
            bit_cnt_q <= CNT_RESET;
            sda_oe_q <= 1'b0;
          end else begin
            // bit 7 went out on the previous fall, so send the next one
            sda_oe_q <= !tx_sh_q[6];
          end
        end
        ST_TX_ACK: begin
          if (nack_q) begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end else begin
            st_q <= ST_TX;
            sda_oe_q <= !(byte_hi_q ? word_q[7] : 1'b0);
          end
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // receive shifter and master acknowledge sampling
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_sh_q <= 8'h00;
      nack_q <= 1'b0;
    end else if (start_det) begin
      rx_sh_q <= 8'h00;
    end else if (scl_rise) begin
      if (st_q == ST_ADDR || st_q == ST_RX) begin
        rx_sh_q <= {rx_sh_q[6:0], sda_s};
      end
      if (st_q == ST_TX_ACK) begin
        nack_q <= sda_s;
      end
    end
  end

  // transmit shifter: upper byte first, padded with four zeros
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tx_sh_q <= 8'h00;
      byte_hi_q <= 1'b0;
      word_q <= RESULT_RESET;
    end else if (start_det || stop_det) begin
      byte_hi_q <= 1'b0;
    end else if (load_hi) begin
      // an empty buffer repeats the last result rather than stalling
      if (fifo_rd_valid) begin
        word_q <= fifo_rd_data;
        tx_sh_q <= {HI_BYTE_PAD, fifo_rd_data[11:8]};
      end else begin
        tx_sh_q <= {HI_BYTE_PAD, word_q[11:8]};
      end
      tx_sh_q[7] <= HI_BYTE_PAD[3];
      byte_hi_q <= 1'b1;
    end else if (load_lo) begin
      tx_sh_q <= word_q[7:0];
      byte_hi_q <= 1'b0;
    end else if (scl_fall && st_q == ST_TX && bit_cnt_q != BYTE_BITS) begin
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
    end
  end

  // command capture, routing and conversion request
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cmd_q <= CMD_RESET;
      ref_pend_q <= 1'b0;
      conv_pend_q <= 1'b0;
      route_q <= '0;
      mode_q <= 1'b0;
    end else begin
      if (rx_done) begin
        cmd_q <= rx_sh_q;
        ref_pend_q <= rx_sh_q[3];
        mode_q <= rx_sh_q[7];
        conv_pend_q <= 1'b1;
        if (rx_sh_q[7]) begin
          route_q.pos_ch <= {rx_sh_q[5:4], rx_sh_q[6]};
          route_q.neg_ch <= 3'h0;
          route_q.neg_common_input <= 1'b1;
        end else begin
          route_q.pos_ch <= {rx_sh_q[5:4], rx_sh_q[6]};
          route_q.neg_ch <= {rx_sh_q[5:4], !rx_sh_q[6]};
          route_q.neg_common_input <= 1'b0;
        end
      end else if (conv_start_q) begin
        conv_pend_q <= 1'b0;
      end
    end
  end

  // a full result buffer holds the request until room frees up
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      conv_start_q <= 1'b0;
      conv_busy_q <= 1'b0;
    end else begin
      conv_start_q <= conv_pend_q && !conv_busy_q && !conv_start_q &&
                      fifo_wr_ready;
      if (conv_start_q) begin
        conv_busy_q <= 1'b1;
      end else if (CONV_DONE) begin
        conv_busy_q <= 1'b0;
      end
    end
  end

  // reference follows the last command only at a STOP or repeated START
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ref_on_q <= 1'b0;
    end else if (start_det || stop_det) begin
      ref_on_q <= ref_pend_q;
    end
  end

  // power and clock gating of the core
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      addressed_q <= 1'b0;
      clk_en_q <= 1'b0;
      conv_pwr_q <= 1'b0;
    end else begin
      addressed_q <= (st_q != ST_IDLE) && (st_q != ST_ADDR);
      clk_en_q <= conv_busy_q || conv_pend_q || addressed_q;
      conv_pwr_q <= conv_busy_q || conv_pend_q || addressed_q ||
                    cmd_q.conv_power_sel;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_q;
  assign CONV_START = conv_start_q;
  assign MUX_ROUTE = route_q;
  assign INPUT_MODE_SEL = mode_q;
  assign REF_ON = ref_on_q;
  assign CONV_POWER_ON = conv_pwr_q;
  assign CORE_CLK_EN = clk_en_q;
  assign ADDRESSED = addressed_q;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  a_start_counters: assert property (start_det |=>
    st_q == ST_ADDR && bit_cnt_q == CNT_RESET)
    else $error("start did not restart address reception");
  a_stop_release: assert property (stop_det |=>
    st_q == ST_IDLE && !SDA_OE)
    else $error("stop did not release the bus");
  a_addr_ack_drive: assert property ((st_q == ST_ADDR && scl_fall &&
    bit_cnt_q == BYTE_BITS && addr_match && !start_det && !stop_det)
    |=> SDA_OE && st_q == ST_ADDR_ACK)
    else $error("matching address not acknowledged");
  a_addr_silent: assert property ((st_q == ST_ADDR && scl_fall &&
    bit_cnt_q == BYTE_BITS && !addr_match && !start_det && !stop_det)
    |=> !SDA_OE && st_q == ST_IDLE)
    else $error("foreign address acknowledged");
  a_high_stable: assert property ((scl_s && scl_p_q && !start_det &&
    !stop_det) |=> $stable(sda_oe_q) || !scl_p_q)
    else $error("data drive changed while clock high");
  a_cmd_convert: assert property (rx_done |=> conv_pend_q
    ##[1:40] conv_start_q || !fifo_wr_ready || conv_busy_q)
    else $error("command did not request a conversion");
  a_ref_deferred: assert property (!$stable(ref_on_q) |->
    $past(start_det || stop_det))
    else $error("reference changed outside a condition");
  a_nack_release: assert property ((st_q == ST_TX_ACK && scl_fall &&
    nack_q && !start_det && !stop_det) |=> !SDA_OE && st_q == ST_IDLE)
    else $error("slave kept data after master nack");
  a_clk_gate: assert property ((!conv_busy_q && !conv_pend_q &&
    !addressed_q) [*2] |-> !CORE_CLK_EN)
    else $error("core clock running while idle");
  a_hi_pad: assert property (load_hi |=> tx_sh_q[7:4] == HI_BYTE_PAD)
    else $error("upper result byte not zero padded");

  c_write_cmd: cover property (rx_done);
  c_read_nack: cover property (st_q == ST_TX_ACK && scl_fall && nack_q);
  c_rep_start: cover property (start_det && st_q != ST_IDLE);
  c_conv_done: cover property (conv_busy_q ##1 CONV_DONE);
endmodule : adc_i2c_slave

// ==== shared/adc_cmd_pkg.sv ====
// Purpose: shared constants and types for the two-wire converter slave
// Assumes: one system clock, link pins sampled through synchronisers
// Notes: the address prefix below is an arbitrary neutral value
package adc_cmd_pkg;

  localparam int RESULT_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_RESET = 4'h0;
  // arbitrary value, not taken from any part
  localparam logic [4:0] DEV_PREFIX = 5'h0b;
  localparam logic RW_READ = 1'b1;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] STRAP_CNT_RESET = 2'h0;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [3:0] HI_BYTE_PAD = 4'h0;
  localparam logic [1:0] PD_BETWEEN = 2'h0;
  localparam logic [1:0] PD_REF_OFF_CONV_ON = 2'h1;
  localparam logic [1:0] PD_REF_ON_CONV_OFF = 2'h2;
  localparam logic [1:0] PD_BOTH_ON = 2'h3;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX = 7'h08,
    ST_RX_ACK = 7'h10,
    ST_TX = 7'h20,
    ST_TX_ACK = 7'h40
  } state_e;

  typedef struct packed {
    logic input_mode_sel;
    logic chan_sel_bit2;
    logic chan_sel_bit1;
    logic chan_sel_bit0;
    logic ref_power_sel;
    logic conv_power_sel;
    logic [1:0] unused;
  } cmd_s;

  typedef struct packed {
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
    logic neg_common_input;
  } route_s;

endpackage : adc_cmd_pkg

// ==== verilog/sync2.sv ====
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: inputs are slow compared with the system clock
// Notes: the first stage is read only by the second stage
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // synchronised output
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sync2

// ==== verilog/result_fifo.sv ====
// Purpose: result buffer between the converter core and the serial reader
// Assumes: single clock, one write and one read per cycle at most
// Notes: read data is the head word, valid while not empty
`timescale 1ns/10ps
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic wr_valid, // word offered
  output logic wr_ready, // room for a word
  input wire logic [WIDTH-1:0] wr_data, // word in
  output logic rd_valid, // head word present
  input wire logic rd_ready, // head word taken
  output logic [WIDTH-1:0] rd_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  logic full;
  logic empty;

  assign empty = (wptr_q == rptr_q);
  assign full = (wptr_q[AW] != rptr_q[AW]) &&
                (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = mem[rptr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (wr_valid && !full) begin
      mem[wptr_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (wr_valid && !full) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (rd_ready && !empty) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end
endmodule : result_fifo

// ==== bench/i2c_mst.sv ====
// Purpose: bus master model for the two-wire converter slave
// Assumes: steps on CLK_SYS falling edges, 8 cycles per half link period
// Notes: lines are open drain with pull-ups, so released reads as high
`timescale 1ns/10ps
module i2c_mst (
  input wire logic clk, // bench clock, paces the link timing
  input wire logic sda_line, // resolved data line
  output logic scl, // serial clock, stands high outside frames
  output logic sda_drv // 0 pulls data low, 1 releases it
);
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // data moves only mid-low so no false condition appears
  task automatic bit_out(input logic b);
    wt(4);
    sda_drv = b;
    wt(4);
    scl = 1'h1;
    wt(8);
    scl = 1'h0;
  endtask : bit_out
  task automatic bit_in(output logic b);
    wt(4);
    sda_drv = 1'h1;
    wt(4);
    scl = 1'h1;
    wt(4);
    b = sda_line;
    wt(4);
    scl = 1'h0;
  endtask : bit_in
  // also used as a repeated start from a clock-low point
  task automatic start();
    wt(4);
    sda_drv = 1'h1;
    wt(4);
    scl = 1'h1;
    wt(8);
    sda_drv = 1'h0;
    wt(8);
    scl = 1'h0;
  endtask : start
  task automatic stop();
    wt(4);
    sda_drv = 1'h0;
    wt(4);
    scl = 1'h1;
    wt(8);
    sda_drv = 1'h1;
    wt(8);
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask : wr_byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask : rd_byte
endmodule : i2c_mst

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the two-wire converter slave
// Assumes: straps tied high/low, core model answers 12 cycles after start
// Notes: expected words come from a queue fed by the core model
`timescale 1ns/10ps
module tb;
  import adc_cmd_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_n, scl, sda_drv, sda_line, sda_out, sda_oe;
  logic conv_start, conv_done = 1'h0, ref_on, conv_power_on, core_clk_en;
  logic addressed, input_mode_sel, ref_exp;
  logic strap_hi = 1'h1;
  logic strap_lo = 1'h0;
  logic [RESULT_W-1:0] conv_result = 12'h000, next_val = 12'h5a3, last_word;
  logic [RESULT_W-1:0] exp_q[$];
  route_s mux_route;
  int failures = 0;
  int n_tests = 0;
  int n_start = 0;
  always #5 clk_sys = ~clk_sys;
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  i2c_mst u_i2c_mst (.clk(clk_sys), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv));
  adc_i2c_slave u_adc_i2c_slave (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ADDR_STRAP_HI(strap_hi), .ADDR_STRAP_LO(strap_lo),
    .CONV_START(conv_start),
    .CONV_DONE(conv_done), .CONV_RESULT(conv_result),
    .MUX_ROUTE(mux_route), .INPUT_MODE_SEL(input_mode_sel),
    .REF_ON(ref_on), .CONV_POWER_ON(conv_power_on),
    .CORE_CLK_EN(core_clk_en), .ADDRESSED(addressed));
  always @(posedge clk_sys) if (conv_start === 1'h1) n_start <= n_start + 1;
  // core model; a stale result is inverted so it cannot match by luck
  always begin
    @(posedge clk_sys iff conv_start === 1'h1);
    repeat (12) @(negedge clk_sys);
    conv_result = next_val;
    conv_done = 1'h1;
    exp_q.push_back(next_val);
    @(negedge clk_sys);
    conv_done = 1'h0;
    conv_result = ~next_val;
    next_val = next_val + 12'h3a7;
  end
  task automatic chk(input string what, input logic [11:0] exp,
    input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic do_write(input logic [7:0] c, input int n);
    logic a;
    u_i2c_mst.start();
    u_i2c_mst.wr_byte({DEV_PREFIX, strap_hi, strap_lo, 1'h0}, a);
    chk("write addr ack", 1, a);
    repeat (n) begin
      u_i2c_mst.wr_byte(c, a);
      chk("cmd ack", 1, a);
    end
    chk("ref before stop", ref_exp, ref_on);
    u_i2c_mst.stop();
    ref_exp = c[3];
    chk("ref after stop", ref_exp, ref_on);
  endtask : do_write
  task automatic do_read(input int n);
    logic a;
    logic [7:0] b0, b1;
    u_i2c_mst.start();
    u_i2c_mst.wr_byte({DEV_PREFIX, strap_hi, strap_lo, 1'h1}, a);
    chk("read addr ack", 1, a);
    for (int w = 0; w < n; w++) begin
      if (exp_q.size() > 0) last_word = exp_q.pop_front();
      u_i2c_mst.rd_byte(1'h0, b0);
      chk("upper byte", {4'h0, last_word[11:8]}, b0);
      u_i2c_mst.rd_byte(w == n - 1, b1);
      chk("lower byte", last_word[7:0], b1);
    end
    u_i2c_mst.wt(6);
    chk("released after nack", 0, sda_oe);
    u_i2c_mst.stop();
  endtask : do_read
  task automatic t_bad_addr();
    logic a;
    logic [7:0] adr;
    for (int i = 0; i < 2; i++) begin
      adr = i ? {DEV_PREFIX ^ 5'h01, strap_hi, strap_lo, 1'h0} :
                {DEV_PREFIX, ~strap_hi, strap_lo, 1'h0};
      u_i2c_mst.start();
      u_i2c_mst.wr_byte(adr, a);
      chk("bad addr ack", 0, a);
      u_i2c_mst.wr_byte(8'hff, a);
      chk("ignored byte ack", 0, a);
      chk("not addressed", 0, addressed);
      u_i2c_mst.stop();
    end
    chk("no start", 0, 12'(n_start));
  endtask : t_bad_addr
  task automatic t_cmds();
    logic [7:0] c;
    logic [2:0] ch;
    int s0;
    for (int k = 0; k < 16; k++) begin
      c = {k[3:0], k[1:0], 2'h3};
      ch = {c[5], c[4], c[6]};
      s0 = n_start;
      do_write(c, 1);
      u_i2c_mst.wt(30);
      chk("starts", 1, 12'(n_start - s0));
      chk("mode", c[7], input_mode_sel);
      chk("pos", ch, mux_route.pos_ch);
      if (!c[7]) chk("neg", ch ^ 3'h1, mux_route.neg_ch);
      chk("common", c[7], mux_route.neg_common_input);
      chk("conv power", c[2], conv_power_on);
      chk("core clock", 0, core_clk_en);
      do_read(1);
    end
  endtask : t_cmds
  task automatic t_restart();
    logic a;
    u_i2c_mst.start();
    for (int i = 0; i < 3; i++) u_i2c_mst.bit_out(1'h1);
    u_i2c_mst.start();
    u_i2c_mst.wr_byte({DEV_PREFIX, strap_hi, strap_lo, 1'h0}, a);
    chk("addr after restart", 1, a);
    chk("addressed", 1, addressed);
    chk("core clock on", 1, core_clk_en);
    u_i2c_mst.wr_byte(8'h84, a);
    chk("ref held", ref_exp, ref_on);
    u_i2c_mst.start();
    chk("ref at restart", 0, ref_on);
    u_i2c_mst.stop();
    ref_exp = 1'h0;
    u_i2c_mst.wt(30);
    do_read(1);
  endtask : t_restart
  task automatic t_fifo();
    logic a;
    int s0;
    s0 = n_start;
    u_i2c_mst.start();
    u_i2c_mst.wr_byte({DEV_PREFIX, strap_hi, strap_lo, 1'h0}, a);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      u_i2c_mst.wr_byte(8'h04, a);
      chk("burst ack", 1, a);
    end
    u_i2c_mst.stop();
    u_i2c_mst.wt(30);
    chk("starts when full", FIFO_DEPTH, 12'(n_start - s0));
    do_read(FIFO_DEPTH + 2);
    chk("pending start", FIFO_DEPTH + 1, 12'(n_start - s0));
    chk("drained", 0, 12'(exp_q.size()));
  endtask : t_fifo
  initial begin
    #500000;
    failures++;
    end_of_test();
  end
  initial begin
    rst_n = 1'h0;
    last_word = 12'h000;
    ref_exp = 1'h0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'h1;
    repeat (6) @(negedge clk_sys);
    chk("idle outs", 0, {sda_oe, addressed, core_clk_en, ref_on});
    t_bad_addr();
    t_cmds();
    t_restart();
    t_fifo();
    end_of_test();
  end
endmodule : tb
